// *** rcb_pkg.sv ***
// Constants and voltage lookup functions for the regulator configuration registers.
package rcb_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] RCB_ADDR_SECOND = 8'h13;
	localparam logic [7:0] RCB_ADDR_SWITCH = 8'h14;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int unsigned RCB_TRACK_BIT = 6;
	localparam int unsigned RCB_MODE_BIT  = 5;
	localparam logic [7:0]  RCB_SECOND_RST  = 8'h38;
	localparam logic [7:0]  RCB_SECOND_MASK = 8'h7f;
	localparam logic [7:0]  RCB_SWITCH_MASK = 8'h3f;
	// Variant 0 resets to switch mode, variant 1 to all code bits set, variants 2 and 3 alike.
	localparam logic [7:0]  RCB_SWITCH_RST_TBL [0:3] = '{8'h06, 8'h3f, 8'h26, 8'h26};
	localparam int unsigned RCB_VARIANTS  = 4;
	localparam int unsigned RCB_MV_W      = 12;

	// ----------------------------------------
	// Voltage tables in millivolts
	// ----------------------------------------
	function automatic logic [11:0] rcb_second_mv(input logic [5:0] code);
		logic [11:0] c;
		c = {6'h00, code};
		if (code <= 6'h18)
			return 12'h384 + 12'h019 * c;
		else if (code < 6'h20)
			return 12'h5dc + 12'h032 * (c - 12'h018);
		else if (code < 6'h30)
			return 12'h76c + 12'h032 * (c - 12'h020);
		else if (code < 6'h35)
			return 12'ha8c + 12'h032 * (c - 12'h030);
		else if (code == 6'h35)
			return 12'hbb8;
		else if (code == 6'h36)
			return 12'hc1c;
		else if (code == 6'h37)
			return 12'hc80;
		else
			return 12'hce4;
	endfunction : rcb_second_mv

	function automatic logic [11:0] rcb_third_mv(input logic [4:0] code);
		logic [11:0] c;
		c = {7'h00, code};
		if (code <= 5'h08)
			return 12'h5dc + 12'h032 * c;
		else if (code <= 5'h0d)
			return 12'h7d0 + 12'h064 * (c - 12'h009);
		else
			return 12'h992 + 12'h032 * (c - 12'h00e);
	endfunction : rcb_third_mv

endpackage : rcb_pkg

// *** rcb_regulator_config.sv ***
// Regulator configuration register pair with voltage decode.
`timescale 1ns/1ps
// What this block does
// - Tracking bit clear: second regulator uses its own six-bit code.
// - Tracking bit set: second regulator follows the third buck setpoint.
// - Codes 0 to 24 give 0.9 V to 1.5 V in 25 mV steps.
// - Codes 32 to 44 give 1.9 V to 2.5 V in 50 mV steps.
// - Codes 48 to 55 give 2.7 V to 3.2 V; 56 and above give 3.3 V.
// - Bit 7 of the second regulator register reads zero and ignores writes.
// - Switch register at 0x14 accepts writes only while unlocked.
// - Switch register: bits 7-6 read-only, bit 5 mode, bits 4-0 code.
// - Switch register reset value depends on the device variant.
// - Mode clear makes the FET a load switch; set makes it a regulator.
// - Five-bit code acts only in regulator mode, 1.5 V to 3.3 V.
module rcb_regulator_config #(
	parameter int unsigned VARIANT = 0
) (
	input  wire logic                     clock_in,
	input  wire logic                     rst_n_in,
	input  wire logic                     ce_in,
	input  wire logic [7:0]               reg_addr_in,
	input  wire logic [7:0]               reg_wdata_in,
	input  wire logic                     reg_wr_in,
	input  wire logic                     reg_rd_in,
	input  wire logic                     unlock_ok_in,
	input  wire logic [5:0]               third_buck_setpoint_in,
	output logic      [7:0]               reg_rdata_out,
	output logic                          wr_refused_out,
	output logic                          second_track_out,
	output logic      [5:0]               second_code_out,
	output logic      [rcb_pkg::RCB_MV_W-1:0] second_mv_out,
	output logic                          third_mode_out,
	output logic      [4:0]               third_code_out,
	output logic      [rcb_pkg::RCB_MV_W-1:0] third_mv_out
);
	import rcb_pkg::*;

	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (VARIANT >= RCB_VARIANTS) begin : g_bad_variant
		$error("VARIANT must be 0 to 3");
	end

	// Only the four known variants have a reset value for the switch register.
	localparam logic [7:0] SWITCH_RST = RCB_SWITCH_RST_TBL[VARIANT];

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	// The release is synchronised so that every register leaves reset on the same edge.
	logic [1:0] rst_sync_r;
	logic       rst_n;

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [7:0] second_ctrl_r;
	logic [7:0] switch_ctrl_r;
	logic       wr_second;
	logic       wr_switch;

	// Both registers sit behind the password; a locked write is dropped, not queued.
	assign wr_second = ce_in && reg_wr_in && unlock_ok_in && (reg_addr_in == RCB_ADDR_SECOND);
	assign wr_switch = ce_in && reg_wr_in && unlock_ok_in && (reg_addr_in == RCB_ADDR_SWITCH);

	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n)
			second_ctrl_r <= RCB_SECOND_RST;
		else if (wr_second)
			second_ctrl_r <= reg_wdata_in & RCB_SECOND_MASK;
	end

	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n)
			switch_ctrl_r <= SWITCH_RST;
		else if (wr_switch)
			switch_ctrl_r <= reg_wdata_in & RCB_SWITCH_MASK;
	end

	// ----------------------------------------
	// Read port and refusal flag
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n)
			reg_rdata_out <= 8'h00;
		else if (ce_in && reg_rd_in) begin
			unique case (reg_addr_in)
				RCB_ADDR_SECOND: reg_rdata_out <= second_ctrl_r;
				RCB_ADDR_SWITCH: reg_rdata_out <= switch_ctrl_r;
				default:         reg_rdata_out <= 8'h00;
			endcase
		end
	end

	// A mapped write while locked is reported so software can repeat the unlock.
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n)
			wr_refused_out <= 1'b0;
		else if (ce_in)
			wr_refused_out <= reg_wr_in && !unlock_ok_in &&
				(reg_addr_in == RCB_ADDR_SECOND || reg_addr_in == RCB_ADDR_SWITCH);
	end

	// ----------------------------------------
	// Second regulator target
	// ----------------------------------------
	// The buck setpoint comes from logic on this clock, so it is used without a synchroniser.
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			second_track_out <= 1'b0;
			second_code_out  <= 6'h00;
			second_mv_out    <= 12'h000;
		end else if (ce_in) begin
			second_track_out <= second_ctrl_r[RCB_TRACK_BIT];
			if (second_ctrl_r[RCB_TRACK_BIT]) begin
				second_code_out <= third_buck_setpoint_in;
				// The buck voltage table lives elsewhere, so no level is reported while tracking.
				second_mv_out   <= 12'h000;
			end else begin
				second_code_out <= second_ctrl_r[5:0];
				second_mv_out   <= rcb_second_mv(second_ctrl_r[5:0]);
			end
		end
	end

	// ----------------------------------------
	// Third regulator or load switch
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			third_mode_out <= 1'b0;
			third_code_out <= 5'h00;
			third_mv_out   <= 12'h000;
		end else if (ce_in) begin
			third_mode_out <= switch_ctrl_r[RCB_MODE_BIT];
			third_code_out <= switch_ctrl_r[4:0];
			// In switch mode the code has no effect, so no regulated level is reported.
			third_mv_out   <= switch_ctrl_r[RCB_MODE_BIT] ? rcb_third_mv(switch_ctrl_r[4:0]) : 12'h000;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// Second regulator decode, checked one enabled cycle after the register holds the code.
	property p_own_code;
		@(posedge clock_in) disable iff (!rst_n)
		(ce_in && !second_ctrl_r[RCB_TRACK_BIT])
		|=> (second_code_out == $past(second_ctrl_r[5:0]));
	endproperty
	a_own_code: assert property (p_own_code) else $error("own code not applied");

	property p_track;
		@(posedge clock_in) disable iff (!rst_n)
		(ce_in && second_ctrl_r[RCB_TRACK_BIT])
		|=> (second_code_out == $past(third_buck_setpoint_in)) && second_track_out;
	endproperty
	a_track: assert property (p_track) else $error("buck setpoint not followed");

	property p_track_mv_zero;
		@(posedge clock_in) disable iff (!rst_n)
		(ce_in && second_ctrl_r[RCB_TRACK_BIT])
		|=> (second_mv_out == 12'h000);
	endproperty
	a_track_mv_zero: assert property (p_track_mv_zero) else $error("level reported while tracking");

	property p_low_range;
		@(posedge clock_in) disable iff (!rst_n)
		(ce_in && !second_ctrl_r[RCB_TRACK_BIT] && second_ctrl_r[5:0] == 6'h18)
		|=> (second_mv_out == 12'h5dc);
	endproperty
	a_low_range: assert property (p_low_range) else $error("code 24 not 1500 mV");

	property p_mid_range;
		@(posedge clock_in) disable iff (!rst_n)
		(ce_in && !second_ctrl_r[RCB_TRACK_BIT] && second_ctrl_r[5:0] == 6'h2c)
		|=> (second_mv_out == 12'h9c4);
	endproperty
	a_mid_range: assert property (p_mid_range) else $error("code 44 not 2500 mV");

	property p_top_range;
		@(posedge clock_in) disable iff (!rst_n)
		(ce_in && !second_ctrl_r[RCB_TRACK_BIT] && second_ctrl_r[5:3] == 3'h7)
		|=> (second_mv_out == 12'hce4);
	endproperty
	a_top_range: assert property (p_top_range) else $error("high code not 3300 mV");

	// Register access: stored values, reserved bits and the password gate.
	property p_bit7_zero;
		@(posedge clock_in) disable iff (!rst_n)
		(ce_in && reg_rd_in && reg_addr_in == RCB_ADDR_SECOND)
		|=> !reg_rdata_out[7];
	endproperty
	a_bit7_zero: assert property (p_bit7_zero) else $error("reserved bit 7 read as one");

	property p_write_second;
		@(posedge clock_in) disable iff (!rst_n)
		wr_second
		|=> (second_ctrl_r == ($past(reg_wdata_in) & RCB_SECOND_MASK));
	endproperty
	a_write_second: assert property (p_write_second) else $error("second register write not stored");

	property p_locked_hold;
		@(posedge clock_in) disable iff (!rst_n)
		(ce_in && reg_wr_in && !unlock_ok_in && reg_addr_in == RCB_ADDR_SWITCH)
		|=> (switch_ctrl_r == $past(switch_ctrl_r)) && wr_refused_out;
	endproperty
	a_locked_hold: assert property (p_locked_hold) else $error("locked write changed register");

	// The refusal flag is a pulse; a level would hide a second refused write.
	property p_refused_pulse;
		@(posedge clock_in) disable iff (!rst_n)
		(ce_in && wr_refused_out && !reg_wr_in)
		|=> !wr_refused_out;
	endproperty
	a_refused_pulse: assert property (p_refused_pulse) else $error("refusal flag stuck");

	property p_reserved_hi;
		@(posedge clock_in) disable iff (!rst_n)
		(ce_in && reg_rd_in && reg_addr_in == RCB_ADDR_SWITCH)
		|=> (reg_rdata_out[7:6] == 2'h0);
	endproperty
	a_reserved_hi: assert property (p_reserved_hi) else $error("reserved bits 7-6 read as one");

	property p_write_switch;
		@(posedge clock_in) disable iff (!rst_n)
		wr_switch
		|=> (switch_ctrl_r == ($past(reg_wdata_in) & RCB_SWITCH_MASK));
	endproperty
	a_write_switch: assert property (p_write_switch) else $error("unlocked write not stored");

	property p_third_code;
		@(posedge clock_in) disable iff (!rst_n)
		ce_in
		|=> (third_code_out == $past(switch_ctrl_r[4:0]));
	endproperty
	a_third_code: assert property (p_third_code) else $error("third code not shown");

	property p_reset_val;
		@(posedge clock_in)
		$rose(rst_n)
		|-> (switch_ctrl_r == SWITCH_RST) && (second_ctrl_r == RCB_SECOND_RST);
	endproperty
	a_reset_val: assert property (p_reset_val) else $error("wrong reset value");

	// Third regulator or load switch.
	property p_switch_mode;
		@(posedge clock_in) disable iff (!rst_n)
		(ce_in && !switch_ctrl_r[RCB_MODE_BIT])
		|=> !third_mode_out && (third_mv_out == 12'h000);
	endproperty
	a_switch_mode: assert property (p_switch_mode) else $error("switch mode reports a level");

	property p_third_ends;
		@(posedge clock_in) disable iff (!rst_n)
		(ce_in && switch_ctrl_r[RCB_MODE_BIT] && (switch_ctrl_r[4:0] == 5'h00 || switch_ctrl_r[4:0] == 5'h1f))
		|=> (third_mv_out == ($past(switch_ctrl_r[4]) ? 12'hce4 : 12'h5dc));
	endproperty
	a_third_ends: assert property (p_third_ends) else $error("regulator end codes wrong");

	// Bus housekeeping: unmapped reads, read data hold and the clock enable.
	property p_unmapped_rd;
		@(posedge clock_in) disable iff (!rst_n)
		(ce_in && reg_rd_in && reg_addr_in != RCB_ADDR_SECOND && reg_addr_in != RCB_ADDR_SWITCH)
		|=> (reg_rdata_out == 8'h00);
	endproperty
	a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

	property p_rdata_hold;
		@(posedge clock_in) disable iff (!rst_n)
		!(ce_in && reg_rd_in)
		|=> $stable(reg_rdata_out);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");

	property p_ce_freeze;
		@(posedge clock_in) disable iff (!rst_n)
		!ce_in
		|=> $stable(switch_ctrl_r) && $stable(second_ctrl_r) && $stable(third_mv_out) && $stable(second_code_out);
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");

	// ----------------------------------------
	// Cover points
	// ----------------------------------------
	c_track_on: cover property (@(posedge clock_in) disable iff (!rst_n)
		wr_second && reg_wdata_in[RCB_TRACK_BIT] ##1 ce_in ##1 second_track_out);
	c_refused: cover property (@(posedge clock_in) disable iff (!rst_n) wr_refused_out);
	c_reg_mode: cover property (@(posedge clock_in) disable iff (!rst_n)
		wr_switch && reg_wdata_in[RCB_MODE_BIT] ##1 ce_in ##1 third_mode_out);
	c_ce_freeze: cover property (@(posedge clock_in) disable iff (!rst_n) !ce_in && reg_wr_in);

endmodule : rcb_regulator_config

// *** rcb_host_model.sv ***
// Host model that reaches the register pair through the block's strobe protocol.
`timescale 1ns/1ps
module rcb_host_model (
	input  wire logic       clock_in,
	input  wire logic [7:0] reg_rdata_in,
	output logic      [7:0] reg_addr_out,
	output logic      [7:0] reg_wdata_out,
	output logic            reg_wr_out,
	output logic            reg_rd_out,
	output logic            unlock_ok_out
);
	initial begin
		reg_addr_out  = 8'h00;
		reg_wdata_out = 8'h00;
		reg_wr_out    = 1'b0;
		reg_rd_out    = 1'b0;
		unlock_ok_out = 1'b0;
	end

	// Unlock is held only for the write it covers, so a stale unlock never leaks into later cycles.
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic unl);
		@(posedge clock_in);
		#1;
		reg_addr_out  = a;
		reg_wdata_out = d;
		unlock_ok_out = unl;
		reg_wr_out    = 1'b1;
		@(posedge clock_in);
		#1;
		reg_wr_out    = 1'b0;
		unlock_ok_out = 1'b0;
		reg_wdata_out = ~d;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_in);
		#1;
		reg_addr_out = a;
		reg_rd_out   = 1'b1;
		@(posedge clock_in);
		#1;
		reg_rd_out = 1'b0;
		d          = reg_rdata_in;
	endtask : rd_reg
endmodule : rcb_host_model

// *** regulator_config_registers_tb_top.sv ***
// Self-checking testbench for the regulator configuration register pair.
`timescale 1ns/1ps
module regulator_config_registers_tb_top;
	logic        clock_in;
	logic        rst_n_in;
	logic        ce;
	logic [7:0]  addr, wdata, rdata, rd_v;
	logic        wr, rd, unl, refused, track, mode;
	logic [5:0]  buck3, second_code;
	logic [4:0]  third_code;
	logic [11:0] second_mv, third_mv;
	int          miscompares;
	int          samples_checked;
	logic [5:0]  codes [11] = '{6'h00, 6'h18, 6'h20, 6'h2c, 6'h30, 6'h34, 6'h35, 6'h36, 6'h37, 6'h38, 6'h3f};
	logic [11:0] mvs [11]   = '{12'h384, 12'h5dc, 12'h76c, 12'h9c4, 12'ha8c, 12'hb54, 12'hbb8, 12'hc1c, 12'hc80,
		12'hce4, 12'hce4};

	rcb_host_model host (.clock_in(clock_in), .reg_rdata_in(rdata), .reg_addr_out(addr), .reg_wdata_out(wdata),
		.reg_wr_out(wr), .reg_rd_out(rd), .unlock_ok_out(unl));

	// Variant 2 chosen so that reset comes up in regulator mode with code 6 (1800 mV).
	rcb_regulator_config #(.VARIANT(2)) dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .unlock_ok_in(unl),
		.third_buck_setpoint_in(buck3), .reg_rdata_out(rdata), .wr_refused_out(refused),
		.second_track_out(track), .second_code_out(second_code), .second_mv_out(second_mv),
		.third_mode_out(mode), .third_code_out(third_code), .third_mv_out(third_mv));

	initial begin
		clock_in = 1'b0;
		forever #4 clock_in = ~clock_in;
	end

	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic settle();
		@(posedge clock_in);
		#1;
	endtask : settle

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	initial begin
		#100000;
		miscompares++;
		conclude();
	end

	initial begin
		miscompares     = 0;
		samples_checked = 0;
		ce              = 1'b1;
		buck3           = 6'h2a;
		rst_n_in        = 1'b0;
		repeat (5) @(posedge clock_in);
		#1;
		rst_n_in = 1'b1;
		repeat (3) settle();
		host.rd_reg(8'h13, rd_v);
		chk("second reset", 12'h038, {4'h0, rd_v});
		host.rd_reg(8'h14, rd_v);
		chk("switch reset", 12'h026, {4'h0, rd_v});
		chk("third reset mv", 12'h708, third_mv);
		host.wr_reg(8'h14, 8'hff, 1'b1);
		host.rd_reg(8'h14, rd_v);
		chk("switch readback", 12'h03f, {4'h0, rd_v});
		chk("third top mv", 12'hce4, third_mv);
		chk("third mode on", 12'h001, {11'h0, mode});
		host.wr_reg(8'h14, 8'h20, 1'b1);
		settle();
		chk("third low mv", 12'h5dc, third_mv);
		host.wr_reg(8'h14, 8'h1f, 1'b1);
		settle();
		chk("third switch mv", 12'h000, third_mv);
		chk("third code", 12'h01f, {7'h0, third_code});
		host.wr_reg(8'h14, 8'h2a, 1'b0);
		chk("refused", 12'h001, {11'h0, refused});
		settle();
		chk("refused drop", 12'h000, {11'h0, refused});
		host.rd_reg(8'h14, rd_v);
		chk("locked keeps", 12'h01f, {4'h0, rd_v});
		host.wr_reg(8'h13, 8'hff, 1'b1);
		host.rd_reg(8'h13, rd_v);
		chk("second readback", 12'h07f, {4'h0, rd_v});
		buck3 = 6'h15;
		settle();
		chk("track code", 12'h015, {6'h0, second_code});
		chk("track flag", 12'h001, {11'h0, track});
		chk("track mv", 12'h000, second_mv);
		for (int i = 0; i < 11; i++) begin
			host.wr_reg(8'h13, {2'b00, codes[i]}, 1'b1);
			settle();
			chk("second mv", mvs[i], second_mv);
			chk("second code", {6'h0, codes[i]}, {6'h0, second_code});
		end
		ce = 1'b0;
		host.wr_reg(8'h14, 8'h3f, 1'b1);
		settle();
		ce = 1'b1;
		host.rd_reg(8'h14, rd_v);
		chk("enable low write", 12'h01f, {4'h0, rd_v});
		rst_n_in = 1'b0;
		repeat (2) settle();
		rst_n_in = 1'b1;
		repeat (3) settle();
		host.rd_reg(8'h14, rd_v);
		chk("second reset run", 12'h026, {4'h0, rd_v});
		chk("second reset mv", 12'h708, third_mv);
		host.rd_reg(8'h12, rd_v);
		chk("unmapped", 12'h000, {4'h0, rd_v});
		conclude();
	end
endmodule : regulator_config_registers_tb_top
